// ---- verilog/pfm_top.sv ----
// Press fault monitor: supervises press control commands and feedback,
// latches fault codes and drives the stop outputs; APB registers.
// Assumes discrete inputs are synchronous to pclk; analog values come digitised.
//
// What this block does
// - Any 100-level fault stops the press and flags main motor stop.
// - Tach speed above reference plus overspeed margin raises 101.
// - Any 200-level fault stops the press, main motor keeps running.
// - Set point at zero after an accepted run raises 204.
// - Tach pulses missing for the tach-loss interval raises 205.
// - Motion against commanded direction beyond degree limit raises 206.
// - Lost phase, or sag over 20% beyond 100 ms, raises 207.
// - Enables without clutch-on within the timeout raise 208.
// - Contactor feedback lingering after clutch-on drops raises 209.
// - Enables disagreeing beyond timeout raise 210 or 213.
// - Inch and micro inch together with an enable raise 211.
// - Reverse without inch or micro inch raises 212.
// - Enables and clutch-on without contactor feedback in time raise 218.
// - Enables or clutch-on seen at power-up or fault reset raise 219.
// - Contactor on beyond the maximum on time raises 223.
// - Stop-on-top overrunning its allowed angular span raises 224.
// - Clutch-on dropped with enables, or before release delay, raises 225.
// - Stop angle reached above creep speed raises 226.
// - Enabling during cooldown raises 227 (clutch) or 228 (brake).
// - No data from control processor within comm timeout raises 231.
// - Control processor takes commands and returns data several times a second.
// - Current fault and four prior codes kept as four BCD digits.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module pfm_top
  import pfm_pkg::*;
#(
  parameter int PTICK = TICK_CYCLES
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        enable_a,
  input  wire logic        enable_b,
  input  wire logic        clutch_on,
  input  wire logic        inch,
  input  wire logic        micro_inch,
  input  wire logic        reverse,
  input  wire logic        contactor_fb,
  input  wire logic        tach_pulse,
  input  wire logic [15:0] tach_speed,
  input  wire logic [15:0] speed_ref,
  input  wire logic [15:0] set_point,
  input  wire logic [15:0] wrong_dir_deg,
  input  wire logic        sot_active,
  input  wire logic [15:0] sot_span_deg,
  input  wire logic        stop_angle_hit,
  input  wire logic        phase_lost,
  input  wire logic        line_sag,
  input  wire logic        clutch_cur_fault,
  input  wire logic        brake_cur_fault,
  input  wire logic        ctl_data_valid,
  output logic             stop_press,
  output logic             stop_motor,
  output logic             fault_active,
  output logic      [15:0] fault_code
);

  localparam int NT = 9;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic int lim_idx(input logic [11:0] a);
    lim_idx = NLIM;
    if (a >= OFS_LIM_BASE && a < OFS_LIM_BASE + 12'(4 * NLIM) && a[1:0] == 2'b00)
      lim_idx = int'((a - OFS_LIM_BASE) >> 2);
  endfunction : lim_idx

  function automatic logic [15:0] pick_code(input logic [NF-1:0] d);
    pick_code = '0;
    for (int i = NF - 1; i >= 0; i--)
      if (d[i])
        pick_code = FAULT_CODES[i];
  endfunction : pick_code

  logic [23:0]   lim_q [NLIM];
  logic [23:0]   lim_d [NLIM];
  logic [23:0]   tick_q;
  logic [23:0]   tick_d;
  logic          tick;
  logic          clutch_prev_q;
  logic          run_q;
  logic          run_d;
  logic          chk_q;
  logic          chk_d;
  logic [23:0]   cool_c_q;
  logic [23:0]   cool_c_d;
  logic [23:0]   cool_b_q;
  logic [23:0]   cool_b_d;
  logic          active_q;
  logic          active_d;
  logic          press_q;
  logic          press_d;
  logic          motor_q;
  logic          motor_d;
  logic [31:0]   prdata_q;
  logic [31:0]   prdata_d;
  logic          pready_q;
  logic          pslverr_q;
  logic          pslverr_d;
  logic [NT-1:0] tcond;
  logic [NT-1:0] texp;
  logic [23:0]   tlim [NT];
  logic [NF-1:0] det;
  logic [15:0]   sel_code;
  logic          new_fault;
  logic          fault_reset;
  logic          acc;
  logic          en_both;
  logic          en_any;
  logic          cool_c_busy;
  logic          cool_b_busy;
  logic [15:0]   h_cur;
  logic [15:0]   h_p1;
  logic [15:0]   h_p2;
  logic [15:0]   h_p3;
  logic [15:0]   h_p4;

  // ****************************************
  // Timebase and command state
  // ****************************************
  assign tick        = (tick_q == 24'(PTICK - 1));
  assign en_both     = enable_a && enable_b;
  assign en_any      = enable_a || enable_b;
  assign cool_c_busy = (cool_c_q != 24'h000000);
  assign cool_b_busy = (cool_b_q != 24'h000000);

  always_comb
  begin
    tick_d = tick ? 24'h000000 : tick_q + 24'h000001;
    run_d  = run_q;
    if (!en_any)
      run_d = 1'b0;
    else if (en_both && clutch_on)
      run_d = 1'b1;
    // Window closes only once the press control has gone quiet
    chk_d = chk_q;
    if (fault_reset)
      chk_d = 1'b1;
    else if (!en_any && !clutch_on)
      chk_d = 1'b0;
    cool_c_d = cool_c_q;
    if (clutch_cur_fault)
      cool_c_d = lim_q[L_COOL_C];
    else if (tick && cool_c_busy)
      cool_c_d = cool_c_q - 24'h000001;
    cool_b_d = cool_b_q;
    if (brake_cur_fault)
      cool_b_d = lim_q[L_COOL_B];
    else if (tick && cool_b_busy)
      cool_b_d = cool_b_q - 24'h000001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_q        <= '0;
      clutch_prev_q <= 1'b0;
      run_q         <= 1'b0;
      chk_q         <= 1'b1;
      cool_c_q      <= '0;
      cool_b_q      <= '0;
    end
    else
    begin
      tick_q        <= tick_d;
      clutch_prev_q <= clutch_on;
      run_q         <= run_d;
      chk_q         <= chk_d;
      cool_c_q      <= cool_c_d;
      cool_b_q      <= cool_b_d;
    end
  end

  // ****************************************
  // Timed conditions
  // ****************************************
  assign tcond[0] = en_both && !clutch_on;
  assign tcond[1] = contactor_fb && !clutch_on;
  assign tcond[2] = enable_a != enable_b;
  assign tcond[3] = en_both && clutch_on && !contactor_fb;
  assign tcond[4] = contactor_fb;
  assign tcond[5] = run_q && !tach_pulse;
  assign tcond[6] = !ctl_data_valid;
  assign tcond[7] = line_sag;
  assign tcond[8] = !en_any && clutch_on;
  assign tlim[0]  = lim_q[L_EN_CLUTCH];
  assign tlim[1]  = lim_q[L_CONT_ON];
  assign tlim[2]  = lim_q[L_ENABLE];
  assign tlim[3]  = lim_q[L_CONT_ON];
  assign tlim[4]  = lim_q[L_MAX_ON];
  assign tlim[5]  = lim_q[L_TACH];
  assign tlim[6]  = lim_q[L_COMM];
  assign tlim[7]  = LINE_TICKS;
  assign tlim[8]  = lim_q[L_RELEASE];

  for (genvar g = 0; g < NT; g++)
  begin : g_timer
    pfm_timeout u_timeout (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick),
      .cond    (tcond[g]),
      .limit   (tlim[g]),
      .expired (texp[g])
    );
  end

  // ****************************************
  // Fault detection, index order is priority
  // ****************************************
  assign det[0]  = {1'b0, tach_speed} > {1'b0, speed_ref} + {1'b0, lim_q[L_OVSP][15:0]};
  assign det[1]  = run_q && set_point == 16'h0000;
  assign det[2]  = texp[5];
  assign det[3]  = wrong_dir_deg > lim_q[L_WRONG_DIR][15:0];
  assign det[4]  = phase_lost || texp[7];
  assign det[5]  = texp[0];
  assign det[6]  = texp[1];
  // Enable B missing reads as 210, enable A missing as 213
  assign det[7]  = texp[2] && enable_a;
  assign det[8]  = en_any && inch && micro_inch;
  assign det[9]  = reverse && !inch && !micro_inch;
  assign det[10] = texp[2] && enable_b;
  assign det[11] = texp[3];
  assign det[12] = chk_q && (en_any || clutch_on);
  assign det[13] = texp[4];
  assign det[14] = sot_active && sot_span_deg > lim_q[L_SOT_SPAN][15:0];
  // Falling clutch-on: judged on last cycle's release timer
  assign det[15] = clutch_prev_q && !clutch_on && (en_any || !texp[8]);
  assign det[16] = stop_angle_hit && tach_speed > lim_q[L_CREEP][15:0];
  assign det[17] = en_any && cool_c_busy;
  assign det[18] = en_any && cool_b_busy;
  assign det[19] = texp[6];

  assign sel_code = pick_code(det);
  // A fault arriving with the reset write is kept, not lost
  assign new_fault = (|det) && (!active_q || fault_reset);

  always_comb
  begin
    active_d = active_q;
    press_d  = press_q;
    motor_d  = motor_q;
    if (new_fault)
    begin
      active_d = 1'b1;
      press_d  = 1'b1;
      motor_d  = (sel_code[15:8] == LEVEL_MOTOR);
    end
    else if (fault_reset)
    begin
      active_d = 1'b0;
      press_d  = 1'b0;
      motor_d  = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active_q <= 1'b0;
      press_q  <= 1'b0;
      motor_q  <= 1'b0;
    end
    else
    begin
      active_q <= active_d;
      press_q  <= press_d;
      motor_q  <= motor_d;
    end
  end

  pfm_fault_log u_log (
    .pclk    (pclk),
    .presetn (presetn),
    .log_en  (new_fault),
    .code_in (sel_code),
    .cur     (h_cur),
    .prior1  (h_p1),
    .prior2  (h_p2),
    .prior3  (h_p3),
    .prior4  (h_p4)
  );

  // ****************************************
  // APB slave, no wait states
  // ****************************************
  assign acc         = psel && penable && pready_q;
  assign fault_reset = acc && pwrite && paddr == OFS_CTRL && pwdata[CTRL_FRST];

  always_comb
  begin
    lim_d     = lim_q;
    prdata_d  = '0;
    pslverr_d = 1'b0;
    if (acc && pwrite && lim_idx(paddr) < NLIM)
      lim_d[lim_idx(paddr)] = pwdata[23:0];
    if (psel && !penable)
    begin
      if (paddr == OFS_CTRL)
        prdata_d = '0;
      else if (paddr == OFS_STATUS)
        prdata_d = {28'h0, chk_q, active_q, motor_q, press_q};
      else if (paddr == OFS_FAULT)
        prdata_d = {16'h0, h_cur};
      else if (paddr == OFS_HIST_A)
        prdata_d = {h_p2, h_p1};
      else if (paddr == OFS_HIST_B)
        prdata_d = {h_p4, h_p3};
      else if (lim_idx(paddr) < NLIM)
        prdata_d = {8'h0, lim_q[lim_idx(paddr)]};
      else
        pslverr_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NLIM; i++)
        lim_q[i] <= LIM_RST;
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      lim_q     <= lim_d;
      prdata_q  <= prdata_d;
      pready_q  <= psel && !penable;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign stop_press   = press_q;
  assign stop_motor   = motor_q;
  assign fault_active = active_q;
  assign fault_code   = h_cur;

  // ****************************************
  // Checks
  // ****************************************
  a_motor_stop_set: assert property (@(posedge pclk) disable iff (!presetn)
    new_fault && sel_code[15:8] == LEVEL_MOTOR |=> stop_motor && stop_press)
    else $error("100-level fault did not stop motor");
  a_overspeed_code: assert property (@(posedge pclk) disable iff (!presetn)
    !active_q && tach_speed > speed_ref + lim_q[L_OVSP][15:0] && !speed_ref[15]
    && !lim_q[L_OVSP][15] |=> fault_code == 16'h0101 && fault_active)
    else $error("overspeed not reported as 101");
  a_stop_now_set: assert property (@(posedge pclk) disable iff (!presetn)
    new_fault && sel_code[15:8] != LEVEL_MOTOR |=> stop_press && !stop_motor)
    else $error("200-level fault handled wrongly");
  a_latch_holds: assert property (@(posedge pclk) disable iff (!presetn)
    active_q && !fault_reset |=> fault_active && $stable(fault_code) && stop_press)
    else $error("fault latch changed without reset");
  a_inch_both: assert property (@(posedge pclk) disable iff (!presetn)
    !active_q && enable_a && inch && micro_inch |=> fault_active)
    else $error("inch and micro inch together not faulted");
  a_reverse_alone: assert property (@(posedge pclk) disable iff (!presetn)
    !active_q && reverse && !inch && !micro_inch |=> fault_active)
    else $error("reverse alone not faulted");
  a_startup_check: assert property (@(posedge pclk) disable iff (!presetn)
    chk_q && !active_q && clutch_on |=> fault_active)
    else $error("clutch-on at start not faulted");
  a_reset_clears: assert property (@(posedge pclk) disable iff (!presetn)
    fault_reset && det == '0 |=> !fault_active && !stop_press && !stop_motor)
    else $error("fault reset did not clear");
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready)
    else $error("APB ready timing wrong");

  c_motor_fault: cover property (@(posedge pclk) disable iff (!presetn)
    new_fault && sel_code == 16'h0101);
  c_comm_fault: cover property (@(posedge pclk) disable iff (!presetn)
    new_fault && sel_code == 16'h0231);
  c_reset_then_fault: cover property (@(posedge pclk) disable iff (!presetn)
    fault_reset ##[1:20] new_fault);
  c_history_full: cover property (@(posedge pclk) disable iff (!presetn)
    h_p4 != 16'h0000);

endmodule : pfm_top

// ---- verilog/pfm_pkg.sv ----
// Constants shared by the press fault monitor: timing, register map, fault codes.
// Assumes a 50 MHz pclk and register access over APB.
package pfm_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_MHZ     = 50;
  localparam int          TICK_US     = 1000;
  localparam int          TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int          LINE_MS     = 100;
  localparam logic [23:0] LINE_TICKS  = 24'((LINE_MS * 1000 + TICK_US - 1) / TICK_US);

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_STATUS   = 12'h004;
  localparam logic [11:0] OFS_FAULT    = 12'h008;
  localparam logic [11:0] OFS_HIST_A   = 12'h00c;
  localparam logic [11:0] OFS_HIST_B   = 12'h010;
  localparam logic [11:0] OFS_LIM_BASE = 12'h020;
  localparam int          NLIM         = 13;
  localparam logic [23:0] LIM_RST      = 24'h0003e8;
  localparam int          CTRL_FRST    = 0;
  localparam int          ST_PRESS     = 0;
  localparam int          ST_MOTOR     = 1;
  localparam int          ST_ACTIVE    = 2;
  localparam int          ST_CHECK     = 3;

  // Limit register indices
  localparam int L_EN_CLUTCH = 0;
  localparam int L_CONT_ON   = 1;
  localparam int L_ENABLE    = 2;
  localparam int L_MAX_ON    = 3;
  localparam int L_RELEASE   = 4;
  localparam int L_TACH      = 5;
  localparam int L_COMM      = 6;
  localparam int L_COOL_C    = 7;
  localparam int L_COOL_B    = 8;
  localparam int L_OVSP      = 9;
  localparam int L_WRONG_DIR = 10;
  localparam int L_SOT_SPAN  = 11;
  localparam int L_CREEP     = 12;

  // ****************************************
  // Fault codes, four BCD digits, highest priority first
  // ****************************************
  localparam int NF = 20;
  localparam logic [15:0] FAULT_CODES [NF] = '{
    16'h0101, 16'h0204, 16'h0205, 16'h0206, 16'h0207, 16'h0208, 16'h0209,
    16'h0210, 16'h0211, 16'h0212, 16'h0213, 16'h0218, 16'h0219, 16'h0223,
    16'h0224, 16'h0225, 16'h0226, 16'h0227, 16'h0228, 16'h0231};
  localparam logic [7:0]  LEVEL_MOTOR = 8'h01;

endpackage : pfm_pkg

// ---- verilog/pfm_timeout.sv ----
// Timeout detector: counts timebase ticks while its condition holds.
// Assumes a free-running tick pulse from the parent.
`timescale 1ns/1ps
module pfm_timeout
  import pfm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tick,
  input  wire logic        cond,
  input  wire logic [23:0] limit,
  output logic             expired
);

  logic [23:0] cnt_q;
  logic [23:0] cnt_d;
  logic        exp_q;
  logic        exp_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (!cond)
      cnt_d = '0;
    else if (tick && cnt_q != 24'hffffff)
      cnt_d = cnt_q + 24'h000001;
    exp_d = cond && (cnt_q >= limit);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;

  a_timer_clear: assert property (@(posedge pclk) disable iff (!presetn)
    !cond |=> !expired && cnt_q == 24'h000000)
    else $error("timeout not cleared when condition dropped");
  a_timer_cause: assert property (@(posedge pclk) disable iff (!presetn)
    expired |-> $past(cond) && $past(cnt_q) >= $past(limit))
    else $error("timeout expired without cause");

endmodule : pfm_timeout

// ---- verilog/pfm_fault_log.sv ----
// Fault log: current code plus four prior codes, four BCD digits each.
// Assumes log_en is a one-cycle pulse per new fault.
`timescale 1ns/1ps
module pfm_fault_log
  import pfm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        log_en,
  input  wire logic [15:0] code_in,
  output logic      [15:0] cur,
  output logic      [15:0] prior1,
  output logic      [15:0] prior2,
  output logic      [15:0] prior3,
  output logic      [15:0] prior4
);

  logic [15:0] hist_q [5];
  logic [15:0] hist_d [5];

  always_comb
  begin
    hist_d = hist_q;
    if (log_en)
    begin
      hist_d[0] = code_in;
      for (int i = 1; i < 5; i++)
        hist_d[i] = hist_q[i-1];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < 5; i++)
        hist_q[i] <= '0;
    else
      hist_q <= hist_d;
  end

  assign cur    = hist_q[0];
  assign prior1 = hist_q[1];
  assign prior2 = hist_q[2];
  assign prior3 = hist_q[3];
  assign prior4 = hist_q[4];

  a_history_shift: assert property (@(posedge pclk) disable iff (!presetn)
    log_en |=> prior1 == $past(cur) && prior4 == $past(prior3) && cur == $past(code_in))
    else $error("fault history did not shift");

endmodule : pfm_fault_log

// ---- verif/pfm_press_ctl.sv ----
// Press control stand-in: drives enables, mode commands and the link heartbeat.
// Assumes the bench supplies the wanted command pattern on cmd.
`timescale 1ns/1ps
module pfm_press_ctl
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [5:0] cmd,
  output logic            enable_a,
  output logic            enable_b,
  output logic            clutch_on,
  output logic            inch,
  output logic            micro_inch,
  output logic            reverse,
  output logic            ctl_data_valid
);
  // ****************************************
  // Commands and heartbeat
  // ****************************************
  logic [5:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {reverse, micro_inch, inch, clutch_on, enable_b, enable_a} <= 6'h00;
      cnt_q <= 6'h00;
    end
    else
    begin
      {reverse, micro_inch, inch, clutch_on, enable_b, enable_a} <= cmd;
      cnt_q <= cnt_q + 6'h01;
    end
  end
  // Far more often than a real link, so the comm timeout never trips
  assign ctl_data_valid = (cnt_q == 6'h3f);
endmodule : pfm_press_ctl

// ---- verif/tb.sv ----
// Bench for the press fault monitor: APB master, press control model, fault log model.
// Assumes pfm_pkg constants and the short PTICK used below.
`timescale 1ns/1ps
module tb;
  import pfm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        stop_press, stop_motor, fault_active, phase_lost;
  logic        contactor_fb, clutch_cur_fault, brake_cur_fault;
  logic        enable_a, enable_b, clutch_on, inch, micro_inch, reverse, ctl_data_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] tach_speed, speed_ref, set_point, wrong_dir_deg, fault_code, margin, ref_v;
  logic [5:0]  cmd;
  logic [15:0] hist[$];
  int          num_errors, comparisons, seed, i;

  pfm_press_ctl pc_u (.pclk(pclk), .presetn(presetn), .cmd(cmd), .enable_a(enable_a),
    .enable_b(enable_b), .clutch_on(clutch_on), .inch(inch), .micro_inch(micro_inch),
    .reverse(reverse), .ctl_data_valid(ctl_data_valid));

  pfm_top #(.PTICK(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enable_a(enable_a), .enable_b(enable_b),
    .clutch_on(clutch_on), .inch(inch), .micro_inch(micro_inch), .reverse(reverse),
    .contactor_fb(contactor_fb), .tach_pulse(1'b0), .tach_speed(tach_speed),
    .speed_ref(speed_ref),
    .set_point(set_point), .wrong_dir_deg(wrong_dir_deg), .sot_active(1'b0),
    .sot_span_deg(wrong_dir_deg), .stop_angle_hit(1'b0), .phase_lost(phase_lost),
    .line_sag(1'b0), .clutch_cur_fault(clutch_cur_fault), .brake_cur_fault(brake_cur_fault),
    .ctl_data_valid(ctl_data_valid), .stop_press(stop_press), .stop_motor(stop_motor),
    .fault_active(fault_active), .fault_code(fault_code));

  always #10 pclk = ~pclk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      num_errors++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_fault(input logic [15:0] code, input logic motor);
    int n;
    n = 0;
    while (fault_active !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200)
    begin
      num_errors++;
      close_out();
    end
    @(negedge pclk);
    check("fault_code", {16'h0, fault_code}, {16'h0, code});
    check("stop_press", {31'h0, stop_press}, 32'h1);
    check("stop_motor", {31'h0, stop_motor}, {31'h0, motor});
    hist.push_front(code);
    void'(hist.pop_back());
    @(posedge pclk);
  endtask : wait_fault

  // Inputs quiet first: the latch must hold on its own until the reset write
  task automatic clear;
    cmd        <= 6'h00;
    phase_lost <= 1'b0;
    contactor_fb <= 1'b0;
    tach_speed <= speed_ref;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    check("held", {31'h0, fault_active}, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h1);
    @(negedge pclk);
    check("cleared", {31'h0, stop_press}, 32'h0);
    @(posedge pclk);
  endtask : clear

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, phase_lost} = 6'h00;
    {contactor_fb, clutch_cur_fault, brake_cur_fault} = 3'h0;
    {paddr, pwdata, cmd} = '0;
    seed = 34;
    hist = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    speed_ref = 16'h0100;
    tach_speed = 16'h0100;
    set_point = 16'h0200;
    wrong_dir_deg = 16'($random(seed)) & 16'h00ff;
    margin = 16'($random(seed)) & 16'h00ff;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_LIM_BASE, 32'h0);
    check("lim0", rd, {8'h00, LIM_RST});
    apb(1'b0, 12'hffc, 32'h0);
    check("slverr", {31'h0, err}, 32'h1);
    apb(1'b1, OFS_LIM_BASE + 12'(4 * L_ENABLE), 32'h2);
    apb(1'b1, OFS_LIM_BASE + 12'(4 * L_OVSP), {16'h0, margin});
    cmd <= 6'b011011;
    wait_fault(16'h0211, 1'b0);
    clear();
    cmd <= 6'b100000;
    wait_fault(16'h0212, 1'b0);
    clear();
    // Disagreeing enables must not trip before the two-tick limit
    for (i = 0; i < 2; i++)
    begin
      cmd <= (i == 0) ? 6'b000001 : 6'b000010;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      check("early", {31'h0, fault_active}, 32'h0);
      wait_fault((i == 0) ? 16'h0210 : 16'h0213, 1'b0);
      clear();
    end
    phase_lost <= 1'b1;
    wait_fault(16'h0207, 1'b0);
    clear();
    // Contactor lingering with clutch-on low
    apb(1'b1, OFS_LIM_BASE + 12'(4 * L_CONT_ON), 32'h3);
    contactor_fb <= 1'b1;
    wait_fault(16'h0209, 1'b0);
    clear();
    // Reference and tach move together, so no stale pair is ever seen
    ref_v = 16'($random(seed)) & 16'h0fff;
    speed_ref  <= ref_v;
    tach_speed <= ref_v + margin;
    repeat (10) @(posedge pclk);
    @(negedge pclk);
    check("margin", {31'h0, fault_active}, 32'h0);
    @(posedge pclk);
    tach_speed <= ref_v + margin + 16'h0001;
    wait_fault(16'h0101, 1'b1);
    apb(1'b1, OFS_FAULT, 32'h0);
    apb(1'b0, OFS_FAULT, 32'h0);
    check("fault", rd, {16'h0, hist[0]});
    apb(1'b0, OFS_HIST_A, 32'h0);
    check("hist_a", rd, {hist[2], hist[1]});
    apb(1'b0, OFS_HIST_B, 32'h0);
    check("hist_b", rd, {hist[4], hist[3]});
    apb(1'b0, OFS_STATUS, 32'h0);
    check("status", rd, 32'h00000007);
    clear();
    // Clutch-on still high at the reset write reopens the start check
    phase_lost <= 1'b1;
    cmd        <= 6'b000100;
    wait_fault(16'h0207, 1'b0);
    phase_lost <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h1);
    @(posedge pclk);
    wait_fault(16'h0219, 1'b0);
    clear();
    // Cooldown after a current fault refuses the enables
    for (i = 0; i < 2; i++)
    begin
      {clutch_cur_fault, brake_cur_fault} <= (i == 0) ? 2'b01 : 2'b10;
      @(posedge pclk);
      {clutch_cur_fault, brake_cur_fault} <= 2'b00;
      cmd <= 6'b000011;
      wait_fault((i == 0) ? 16'h0228 : 16'h0227, 1'b0);
      clear();
    end
    close_out();
  end
endmodule : tb
